// ==== hdl/ssfc_core.sv ====
// Supply protection, supply saver and fire control registers with launch logic
// Functional notes
// - Saver enable bits 7-6: 0 off, 1 level one, 2 both levels.
// - Trip select bits 2-0 pick 2.5 V to 3.2 V in 0.1 V steps.
// - Supply below trip level turns output stage off and enters standby.
// - Level one enabled and supply below threshold one applies limit one.
// - Level two enabled and supply below threshold two applies limit two.
// - Supply sampled once at effect start; clamp held for the effect.
// - Fire bit starts whichever process the mode setting selects.
// - Sequencer mode fire plays waveform identifiers from registers 0x0F-0x16.
// - Fire bit reads one while process runs, zero once it completes.
// - Writing zero to fire bit during playback aborts the process at once.
// - External trigger sets fire bit just like a register write.
// - Fire can launch sequencer playback, calibration or diagnostics by mode.
// - Real-time mode with fire set drives signed playback value to load.
`timescale 1ns/1ps
`default_nettype none
module ssfc_core
  import ssfc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_trigger,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] supply_level,
  input  wire logic       supply_below_trip,
  input  wire logic [7:0] overdrive_limit_one,
  input  wire logic [7:0] overdrive_limit_two,
  input  wire logic [7:0] overdrive_nominal,
  input  wire logic [7:0] realtime_playback_value,
  input  wire logic       process_done,
  output logic      [2:0] undervoltage_trip_select,
  output logic            output_stage_enable,
  output logic            standby,
  output logic      [7:0] overdrive_clamp,
  output logic            launch,
  output logic            abort,
  output ssfc_run_t       run,
  output logic      [7:0] load_drive
);

  typedef enum logic [0:0] {
    SSFC_ST_IDLE = 1'b0,
    SSFC_ST_RUN  = 1'b1
  } ssfc_state_t;

  ssfc_prot_cfg_t prot_cfg;
  logic [7:0]     thr_one;
  logic [7:0]     thr_two;
  ssfc_state_t    state;
  ssfc_state_t    next_state;
  ssfc_mode_t     run_mode;
  logic           trig_prev;
  logic [7:0]     picked_clamp;

  ////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes
  wire wr_cfg   = reg_wr && (reg_addr == SSFC_ADDR_PROT_CFG);
  wire wr_thr1  = reg_wr && (reg_addr == SSFC_ADDR_THR_ONE);
  wire wr_thr2  = reg_wr && (reg_addr == SSFC_ADDR_THR_TWO);
  wire wr_fire  = reg_wr && (reg_addr == SSFC_ADDR_FIRE_CTRL);
  wire fire_one = wr_fire && reg_wdata[SSFC_FIRE_BIT];
  wire fire_zero = wr_fire && !reg_wdata[SSFC_FIRE_BIT];

  // Trigger acts on its rising edge so a held level fires only once
  wire trig_rise = ext_trigger && !trig_prev;
  wire fire_req  = fire_one || trig_rise;

  ////////////////////////////////////////////////////////////////////////
  // Launch and end conditions
  // A start needs an idle core and a healthy supply; a fire write of one while
  // busy is dropped, so polling the bit back as one cannot restart an effect
  wire busy      = (state == SSFC_ST_RUN);
  wire start     = !busy && fire_req && !supply_below_trip;
  wire uv_stop   = busy && supply_below_trip;
  wire host_stop = busy && fire_zero;
  // Real-time playback has no natural end; only a clear or a trip stops it
  wire done_stop = busy && process_done && (run_mode != SSFC_MODE_RTP);

  // Next state: a trip or a clear outranks completion
  always_comb begin
    case (state)
      SSFC_ST_IDLE: next_state = start ? SSFC_ST_RUN : SSFC_ST_IDLE;
      SSFC_ST_RUN:  next_state = (uv_stop || host_stop || done_stop) ?
                                 SSFC_ST_IDLE : SSFC_ST_RUN;
      default:      next_state = SSFC_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Clamp candidate from the current supply and saver setting
  ssfc_clamp_select u_clamp_select (
    .saver_enable (prot_cfg.supply_saver_level_enable),
    .supply_level (supply_level),
    .saver        ({thr_one, thr_two, overdrive_limit_one,
                    overdrive_limit_two, overdrive_nominal}),
    .clamp        (picked_clamp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits hold what is written
  // Threshold order is not enforced here; keeping level one above two is up to software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prot_cfg <= SSFC_RST_PROT_CFG;
      thr_one  <= SSFC_RST_THR_ONE;
      thr_two  <= SSFC_RST_THR_TWO;
    end else begin
      if (wr_cfg)  prot_cfg <= reg_wdata;
      if (wr_thr1) thr_one  <= reg_wdata;
      if (wr_thr2) thr_two  <= reg_wdata;
    end
  end

  // Control state, launched mode and trigger history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= SSFC_ST_IDLE;
      run_mode  <= SSFC_MODE_RTP;
      trig_prev <= 1'b0;
    end else begin
      state     <= next_state;
      trig_prev <= ext_trigger;
      if (start) run_mode <= ssfc_mode_t'(mode);
    end
  end

  // Clamp sampled only at the start of an effect, then frozen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overdrive_clamp <= 8'h00;
    end else if (start) begin
      overdrive_clamp <= picked_clamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage and standby: the trip cuts the stage in the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_stage_enable <= 1'b0;
      standby             <= 1'b1;
    end else begin
      output_stage_enable <= (next_state == SSFC_ST_RUN) && !supply_below_trip;
      standby             <= (next_state == SSFC_ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-hot run flags for the mode that owns the core; all clear when idle
  function automatic ssfc_run_t run_flags(input ssfc_mode_t m, input logic on);
    ssfc_run_t f;
    f          = '0;
    f.seq_run  = on && (m == SSFC_MODE_SEQ);
    f.cal_run  = on && (m == SSFC_MODE_CAL);
    f.diag_run = on && (m == SSFC_MODE_DIAG);
    f.rtp_run  = on && (m == SSFC_MODE_RTP);
    return f;
  endfunction

  // A new launch takes the live mode; a running effect keeps the captured one,
  // so a mode change mid-effect cannot retarget the indicators
  wire             going    = (next_state == SSFC_ST_RUN);
  wire ssfc_mode_t eff_mode = start ? ssfc_mode_t'(mode) : run_mode;
  wire ssfc_run_t  next_run = run_flags(eff_mode, going);

  // Process indicators and the real-time load value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run        <= '0;
      load_drive <= 8'h00;
    end else begin
      run        <= next_run;
      // Host may update the value live; zero when not playing in real time
      load_drive <= next_run.rtp_run ? realtime_playback_value : 8'h00;
    end
  end

  // Single-cycle launch and abort strobes for the playback engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      launch <= 1'b0;
      abort  <= 1'b0;
    end else begin
      launch <= start;
      abort  <= uv_stop || host_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; the fire bit reflects the live process state
  // Offsets outside the map read as zero
  wire [7:0] fire_view = {7'h00, busy};
  wire [7:0] rd_mux = (reg_addr == SSFC_ADDR_PROT_CFG)  ? prot_cfg :
                      (reg_addr == SSFC_ADDR_THR_ONE)   ? thr_one  :
                      (reg_addr == SSFC_ADDR_THR_TWO)   ? thr_two  :
                      (reg_addr == SSFC_ADDR_FIRE_CTRL) ? fire_view : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // Trip level code goes straight to the analog comparator
  assign undervoltage_trip_select = prot_cfg.undervoltage_trip_select;

endmodule // ssfc_core
`default_nettype wire

// ==== hdl/ssfc_pkg.sv ====
// Shared constants and types for the supply guard and fire control block
package ssfc_pkg;

  // Register offsets
  localparam logic [7:0] SSFC_ADDR_PROT_CFG  = 8'h09;
  localparam logic [7:0] SSFC_ADDR_THR_ONE   = 8'h0A;
  localparam logic [7:0] SSFC_ADDR_THR_TWO   = 8'h0B;
  localparam logic [7:0] SSFC_ADDR_FIRE_CTRL = 8'h0C;

  // Values after reset
  localparam logic [7:0] SSFC_RST_PROT_CFG  = 8'h00;
  localparam logic [7:0] SSFC_RST_THR_ONE   = 8'h92;
  localparam logic [7:0] SSFC_RST_THR_TWO   = 8'h8D;
  localparam logic [7:0] SSFC_RST_FIRE_CTRL = 8'h00;

  // Field positions
  localparam int SSFC_FIRE_BIT     = 0;
  localparam int SSFC_SAVER_EN_LSB = 6;
  localparam int SSFC_UV_SEL_LSB   = 0;

  // Supply saver enable codes
  localparam logic [1:0] SSFC_SAVER_OFF  = 2'h0;
  localparam logic [1:0] SSFC_SAVER_ONE  = 2'h1;
  localparam logic [1:0] SSFC_SAVER_BOTH = 2'h2;

  // Process selected by the mode setting
  typedef enum logic [1:0] {
    SSFC_MODE_RTP  = 2'b00,
    SSFC_MODE_SEQ  = 2'b01,
    SSFC_MODE_DIAG = 2'b10,
    SSFC_MODE_CAL  = 2'b11
  } ssfc_mode_t;

  // Layout of the supply protection configuration register
  typedef struct packed {
    logic [1:0] supply_saver_level_enable;
    logic [2:0] reserved;
    logic [2:0] undervoltage_trip_select;
  } ssfc_prot_cfg_t;

  // Saver thresholds and limits travel together into the clamp selector
  typedef struct packed {
    logic [7:0] threshold_one;
    logic [7:0] threshold_two;
    logic [7:0] limit_one;
    logic [7:0] limit_two;
    logic [7:0] nominal;
  } ssfc_saver_t;

  // Process run indicators
  typedef struct packed {
    logic seq_run;
    logic cal_run;
    logic diag_run;
    logic rtp_run;
  } ssfc_run_t;

endpackage

// ==== hdl/ssfc_clamp_select.sv ====
// Overdrive clamp selection from the supply level and saver setting
`timescale 1ns/1ps
`default_nettype none
module ssfc_clamp_select
  import ssfc_pkg::*;
(
  input  wire logic [1:0] saver_enable,
  input  wire logic [7:0] supply_level,
  input  wire ssfc_saver_t saver,
  output logic      [7:0] clamp
);

  ////////////////////////////////////////////////////////////////////////
  // Comparisons against both thresholds; code 3 is treated as disabled
  wire lvl_one_on  = (saver_enable == SSFC_SAVER_ONE) ||
                     (saver_enable == SSFC_SAVER_BOTH);
  wire lvl_two_on  = (saver_enable == SSFC_SAVER_BOTH);
  wire below_one   = supply_level < saver.threshold_one;
  wire below_two   = supply_level < saver.threshold_two;

  // Second level wins when both apply, since it is the deeper sag
  assign clamp = (lvl_two_on && below_two) ? saver.limit_two :
                 (lvl_one_on && below_one) ? saver.limit_one :
                 saver.nominal;

endmodule // ssfc_clamp_select
`default_nettype wire

// ==== verification/ssfc_core_props.sv ====
// Checker on the ports of the supply guard and fire control core
`timescale 1ns/1ps
`default_nettype none
module ssfc_core_props
  import ssfc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       ext_trigger,
  input wire logic [1:0] mode,
  input wire logic       supply_below_trip,
  input wire logic       process_done,
  input wire logic       output_stage_enable,
  input wire logic       standby,
  input wire logic [7:0] overdrive_clamp,
  input wire logic       launch,
  input wire logic       abort,
  input wire ssfc_run_t  run
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Host events; a start needs an idle core and a healthy supply
  wire       fire_wr = reg_wr && reg_addr == SSFC_ADDR_FIRE_CTRL;
  wire       go_ok   = standby && !supply_below_trip;
  wire [3:0] want    = {mode == SSFC_MODE_SEQ, mode == SSFC_MODE_CAL,
                        mode == SSFC_MODE_DIAG, mode == SSFC_MODE_RTP};
  sequence s_start;
    (fire_wr && reg_wdata[0] || $rose(ext_trigger)) && go_ok;
  endsequence
  sequence s_clear;
    fire_wr && !reg_wdata[0] && |run;
  endsequence
  a_fire_launch: assert property (s_start |=> launch && output_stage_enable ##1 !launch)
    else $error("launch pulse wrong");
  a_mode_run: assert property (s_start |=> run == $past(want))
    else $error("run does not follow mode");
  a_trigger_fire: assert property ($rose(ext_trigger) && go_ok |=> launch && !standby)
    else $error("trigger did not fire");
  a_done_ends: assert property (process_done && |run && !run.rtp_run && !fire_wr
    && !supply_below_trip |=> run == 0 && standby && !abort) else $error("done ignored");
  a_clear_abort: assert property (s_clear |=> abort && run == 0 ##1 !abort)
    else $error("clear did not abort");
  a_trip_off: assert property (supply_below_trip |=> !output_stage_enable && !launch)
    else $error("stage on under trip");
  a_trip_idle: assert property (supply_below_trip && |run |=> standby && abort)
    else $error("trip left core busy");
  a_clamp_hold: assert property (|run ##1 |run |-> $stable(overdrive_clamp))
    else $error("clamp moved in effect");
endmodule // ssfc_core_props
bind ssfc_core ssfc_core_props ssfc_core_props_inst (.mclk, .rst_n, .reg_wr, .reg_addr,
  .reg_wdata, .ext_trigger, .mode, .supply_below_trip, .process_done, .output_stage_enable,
  .standby, .overdrive_clamp, .launch, .abort, .run);
`default_nettype wire

// ==== verification/ssfc_host.sv ====
// Host model that drives the register strobe bus of the core
`timescale 1ns/1ps
`default_nettype none
module ssfc_host
(
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr = 1'b0,
  output var  logic       reg_rd = 1'b0,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00
);
  // Strobe held over one edge; the bus then shows the inverse so stale data is never taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // ssfc_host
`default_nettype wire

// ==== verification/test_supply_guard_and_fire_control.sv ====
// Self-checking bench for the supply guard and fire control core
`timescale 1ns/1ps
`default_nettype none
module test_supply_guard_and_fire_control
  import ssfc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ext_trigger = 1'b0;
  logic        supply_below_trip = 1'b0;
  logic        process_done = 1'b0;
  logic [1:0]  mode = SSFC_MODE_SEQ;
  logic [7:0]  supply_level = 8'h00;
  logic [7:0]  rtp = 8'h00;
  logic        reg_wr, reg_rd, launch, abort, output_stage_enable, standby;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, overdrive_clamp, load_drive, d;
  logic [5:0]  dly = 6'h00;
  logic [2:0]  uv_sel;
  ssfc_run_t   run;
  int          err_count = 0;
  int          check_count = 0;
  // Saver code, supply code, clamp; the row number is also the trip code
  logic [17:0] rows [8] = '{18'h08070, 18'h19150, 18'h19270, 18'h18050,
                            18'h29050, 18'h28C30, 18'h38070, 18'h28D50};
  logic [7:0]  rst_val [5] = '{SSFC_RST_PROT_CFG, SSFC_RST_THR_ONE, SSFC_RST_THR_TWO,
                               SSFC_RST_FIRE_CTRL, 8'h00};
  logic [23:0] rw [3] = '{24'h093F3F, 24'h0B5A5A, 24'h0DFF00};
  always #5 mclk = ~mclk;
  ssfc_core ssfc_core_inst (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .ext_trigger, .mode, .supply_level, .supply_below_trip,
    .overdrive_limit_one(8'h50), .overdrive_limit_two(8'h30),
    .overdrive_nominal(8'h70), .realtime_playback_value(rtp), .process_done,
    .undervoltage_trip_select(uv_sel), .output_stage_enable, .standby, .overdrive_clamp,
    .launch, .abort, .run, .load_drive);
  ssfc_host ssfc_host_inst (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  ////////////////////////////////////////
  // Engine stand-in: completion seven cycles after each launch; an abort
  // drops the pending completion so it cannot end a later effect
  always @(posedge mclk) begin
    dly <= abort ? 6'h00 : {dly[4:0], launch};
    process_done <= dly[5];
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for idle; a hang ends the run
  task automatic wait_idle;
    int n;
    for (n = 0; n < 40 && standby !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (standby !== 1'b1) begin
      err_count++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      ssfc_host_inst.rd(8'h09 + 8'(a), d);
      chk(d, rst_val[a]);
    end
    for (int j = 0; j < 3; j++) begin
      ssfc_host_inst.wr(rw[j][23:16], rw[j][15:8]);
      ssfc_host_inst.rd(rw[j][23:16], d);
      chk(d, rw[j][7:0]);
    end
    ssfc_host_inst.wr(SSFC_ADDR_THR_TWO, SSFC_RST_THR_TWO);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      supply_level <= rows[i][15:8];
      ssfc_host_inst.wr(SSFC_ADDR_PROT_CFG, {rows[i][17:16], 3'h0, 3'(i)});
      ssfc_host_inst.wr(SSFC_ADDR_FIRE_CTRL, 8'h01);
      #1 chk({7'h0, launch}, 8'h01);
      chk({5'h00, uv_sel}, 8'(i));
      @(posedge mclk);
      supply_level <= 8'h00;
      ssfc_host_inst.rd(SSFC_ADDR_FIRE_CTRL, d);
      chk(d, 8'h01);
      wait_idle();
      chk(overdrive_clamp, rows[i][7:0]);
      ssfc_host_inst.rd(SSFC_ADDR_FIRE_CTRL, d);
      chk(d, 8'h00);
    end
    $display("clamp test done");
    @(posedge mclk);
    mode <= SSFC_MODE_RTP;
    rtp <= 8'h9C;
    ssfc_host_inst.wr(SSFC_ADDR_FIRE_CTRL, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk(load_drive, 8'h9C);
    @(posedge mclk);
    rtp <= 8'h64;
    @(posedge mclk);
    #1 chk(load_drive, 8'h64);
    ssfc_host_inst.wr(SSFC_ADDR_FIRE_CTRL, 8'h00);
    #1 chk({2'h0, abort, standby, run}, 8'h30);
    chk(load_drive, 8'h00);
    $display("abort test done");
    // Trigger pin in diagnostic then calibration mode; a trip ends the second
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      mode <= (k != 0) ? SSFC_MODE_CAL : SSFC_MODE_DIAG;
      ext_trigger <= 1'b1;
      @(posedge mclk);
      ext_trigger <= 1'b0;
      #1 chk({3'h0, launch, run}, 8'h10 | 8'(2 << k));
      if (k == 0) wait_idle();
    end
    @(posedge mclk);
    supply_below_trip <= 1'b1;
    @(posedge mclk);
    #1 chk({5'h0, abort, standby, output_stage_enable}, 8'h06);
    ssfc_host_inst.wr(SSFC_ADDR_FIRE_CTRL, 8'h01);
    #1 chk({6'h0, launch, standby}, 8'h01);
    @(posedge mclk);
    supply_below_trip <= 1'b0;
    $display("trigger and trip test done");
    give_verdict();
  end
endmodule // test_supply_guard_and_fire_control
`default_nettype wire
